// ===== include/ars_pkg.sv
// package: constants and types for the abort release sequencer
`default_nettype none
package ars_pkg;
	localparam int NUM_DET = 6;
	localparam int NUM_IN = 8;
	localparam int IDX_ABORT = 6;
	localparam int IDX_MANUAL = 7;
	localparam int NUM_TMR = 3;
	localparam int TMR_W = 8;
	// clock and time base
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_PERIOD_MS = 1000;
	localparam int TICK_CYCLES = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
	localparam int HORN_BEATS_PER_MIN = 60;
	localparam int HORN_HALF_MS = 60 * 1000 / HORN_BEATS_PER_MIN / 2;
	localparam int HORN_HALF_CYCLES = HORN_HALF_MS * 1000000 / CLK_PERIOD_NS;
	// delays in seconds
	localparam int BASE_DELAY_S = 30;
	localparam int REARM_DELAY_S = 90;
	localparam int POST_ABORT_DELAY_S = BASE_DELAY_S + REARM_DELAY_S;
	localparam int TMR_BASE = 0;
	localparam int TMR_REARM = 1;
	localparam int TMR_POST = 2;
	localparam logic [NUM_TMR*TMR_W-1:0] TMR_LOADS = {
		8'(POST_ABORT_DELAY_S), 8'(REARM_DELAY_S), 8'(BASE_DELAY_S)};
	// register map, byte offsets
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_LATCH = 4'h8;
	localparam logic [3:0] OFS_TIMERS = 4'hC;
	localparam int CTRL_ZONE_EN_BIT = 0;
	localparam logic [0:0] CTRL_RESET = 1'h1;
	// status field positions
	localparam int ST_FIRST = 0;
	localparam int ST_PRE = 1;
	localparam int ST_ABORTED = 2;
	localparam int ST_RELEASED = 3;
	localparam int ST_BELL = 4;
	localparam int ST_HORN = 5;
	localparam int ST_STROBE = 6;
	localparam int ST_AGENT = 7;
	localparam int ST_POWER = 8;
	localparam int ST_HVAC = 9;
	localparam int ST_ABORT_IN = 10;
	localparam int ST_MANUAL_IN = 11;
	typedef enum logic [1:0] {
		HORN_OFF = 2'b00,
		HORN_PULSE = 2'b01,
		HORN_CONT = 2'b10
	} ars_horn_t;
endpackage : ars_pkg
`default_nettype wire

// ===== include/ars_tmr_if.sv
// interface: one delay timer and its controller
`default_nettype none
interface ars_tmr_if;
	logic run;
	logic tick;
	logic [7:0] remaining;
	logic expired;
	modport tmr (input run, input tick, output remaining, output expired);
	modport ctl (output run, output tick, input remaining, input expired);
endinterface : ars_tmr_if
`default_nettype wire

// ===== src/ars_timer.sv
// seconds countdown timer that reloads while disabled
`default_nettype none
module ars_timer
	import ars_pkg::*;
#(
	parameter logic [TMR_W-1:0] LOAD = 8'h1E
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	ars_tmr_if.tmr bus
);
	logic [TMR_W-1:0] count_q;

	always_ff @(posedge mclk) begin
		if (reset) begin
			count_q <= LOAD;
		end else if (ce) begin
			if (!bus.run) begin
				count_q <= LOAD;
			end else if (bus.tick && count_q != 8'h00) begin
				count_q <= count_q - 8'h01;
			end
		end
	end

	assign bus.remaining = count_q;
	assign bus.expired = bus.run && count_q == 8'h00;
endmodule : ars_timer
`default_nettype wire

// ===== src/ars_sequencer.sv
// top: release sequencer for one suppression zone with abort handling
// What this block does
// - first alarm flag sets once, on any detector
// - bell switched on by first alarm and by abort in pre-release
// - two or more detectors set pre-release flag
// - pre-release: bell off, horn pulsing, strobe steady
// - shutdowns asserted at pre-release and at release
// - base countdown runs while pre-release, no abort
// - held abort stops the countdown
// - expiry releases agent, horn goes continuous
// - abort in pre-release: bell back, horn/strobe off
// - after release abort has no effect
// - rearm timer restores pre-release signalling at expiry
// - post-abort timer releases agent and asserts shutdowns
// - post-abort delay is base plus rearm delay
// - manual release bypasses all delays and abort
// - detector alarms latch until system reset
`default_nettype none
module ars_sequencer
	import ars_pkg::*;
#(
	parameter int TICK_CNT = TICK_CYCLES,
	parameter int HORN_HALF_CNT = HORN_HALF_CYCLES
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [NUM_DET-1:0] detector_in,
	input wire logic abort_in,
	input wire logic manual_release_in,
	output logic bell_out,
	output logic horn_out,
	output logic strobe_out,
	output logic agent_release_out,
	output logic power_shutdown_out,
	output logic hvac_shutdown_out
);
	logic [NUM_IN-1:0] pins;
	logic [NUM_IN-1:0] s1_q;
	logic [NUM_IN-1:0] s2_q;
	logic [NUM_IN-1:0] s3_q;
	logic [NUM_IN-1:0] filt_q;
	logic [NUM_DET-1:0] latch_q;
	logic [NUM_DET-1:0] latch_d;
	logic zone_en_q;
	logic first_alarm_flag;
	logic prerelease_flag;
	logic abort_occurred_flag;
	logic released_flag;
	logic pre_d;
	logic abort_f;
	logic manual_f;
	logic abort_evt;
	logic release_evt;
	logic rearm_evt;
	logic pre_entry;
	logic first_entry;
	ars_horn_t horn_mode_q;
	logic bell_q;
	logic horn_q;
	logic strobe_q;
	logic agent_q;
	logic power_q;
	logic hvac_q;
	logic [31:0] tick_cnt_q;
	logic tick;
	logic [31:0] horn_cnt_q;
	logic horn_phase_q;
	logic [NUM_TMR-1:0] run_v;
	logic [NUM_TMR-1:0] exp_v;
	logic [NUM_TMR*TMR_W-1:0] remain_v;
	logic ack_q;
	logic [31:0] rdata_q;
	logic [31:0] status_w;

	assign pins = {manual_release_in, abort_in, detector_in};

	// three-stage synchroniser per pin, change taken when stages 2 and 3 agree
	genvar gi;
	generate
		for (gi = 0; gi < NUM_IN; gi++) begin : g_sync
			always_ff @(posedge mclk) begin
				if (reset) begin
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
					s3_q[gi] <= 1'b0;
					filt_q[gi] <= 1'b0;
				end else if (ce) begin
					s1_q[gi] <= pins[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
					if (s2_q[gi] == s3_q[gi]) begin
						filt_q[gi] <= s3_q[gi];
					end
				end
			end
		end
	endgenerate

	assign abort_f = filt_q[IDX_ABORT];
	assign manual_f = filt_q[IDX_MANUAL];

	// detector alarms latch until reset
	always_comb begin
		latch_d = latch_q;
		if (zone_en_q) begin
			latch_d = latch_q | filt_q[NUM_DET-1:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			latch_q <= '0;
		end else if (ce) begin
			latch_q <= latch_d;
		end
	end

	// more than one latched alarm: clear lowest set bit and test remainder
	assign pre_d = (latch_q & (latch_q - 6'h01)) != 6'h00;
	assign first_entry = (|latch_q) && !first_alarm_flag;
	assign pre_entry = pre_d && !prerelease_flag;
	assign abort_evt = abort_f && prerelease_flag && !released_flag;
	assign rearm_evt = exp_v[TMR_REARM] && !released_flag;
	assign release_evt = !released_flag
		&& (exp_v[TMR_BASE] || exp_v[TMR_POST] || manual_f);

	// sequence flags
	always_ff @(posedge mclk) begin
		if (reset) begin
			first_alarm_flag <= 1'b0;
			prerelease_flag <= 1'b0;
			abort_occurred_flag <= 1'b0;
			released_flag <= 1'b0;
		end else if (ce) begin
			if (first_entry) begin
				first_alarm_flag <= 1'b1;
			end
			if (pre_d) begin
				prerelease_flag <= 1'b1;
			end
			if (abort_evt) begin
				abort_occurred_flag <= 1'b1;
			end
			if (release_evt) begin
				released_flag <= 1'b1;
			end
		end
	end

	// timer enables
	always_comb begin
		run_v[TMR_BASE] = prerelease_flag && !abort_f
			&& !abort_occurred_flag && !released_flag;
		run_v[TMR_REARM] = abort_occurred_flag && !released_flag && !abort_f;
		run_v[TMR_POST] = abort_occurred_flag && !released_flag && !abort_f;
	end

	// one-second time base, restarted while no timer runs
	always_ff @(posedge mclk) begin
		if (reset) begin
			tick_cnt_q <= '0;
		end else if (ce) begin
			if (run_v == '0 || tick) begin
				tick_cnt_q <= '0;
			end else begin
				tick_cnt_q <= tick_cnt_q + 32'h00000001;
			end
		end
	end

	assign tick = tick_cnt_q == 32'(TICK_CNT - 1);

	generate
		for (gi = 0; gi < NUM_TMR; gi++) begin : g_tmr
			ars_tmr_if t_if ();
			ars_timer #(
				.LOAD(TMR_LOADS[gi*TMR_W +: TMR_W])
			) u_tmr (
				.mclk(mclk),
				.reset(reset),
				.ce(ce),
				.bus(t_if.tmr)
			);
			assign t_if.run = run_v[gi];
			assign t_if.tick = tick;
			assign exp_v[gi] = t_if.expired;
			assign remain_v[gi*TMR_W +: TMR_W] = t_if.remaining;
		end
	endgenerate

	// notification appliances; release outranks abort, abort outranks rearm
	always_ff @(posedge mclk) begin
		if (reset) begin
			bell_q <= 1'b0;
			horn_mode_q <= HORN_OFF;
			strobe_q <= 1'b0;
		end else if (ce) begin
			if (release_evt) begin
				bell_q <= 1'b0;
				horn_mode_q <= HORN_CONT;
				strobe_q <= 1'b1;
			end else if (abort_evt) begin
				bell_q <= 1'b1;
				horn_mode_q <= HORN_OFF;
				strobe_q <= 1'b0;
			end else if (rearm_evt) begin
				bell_q <= 1'b0;
				horn_mode_q <= HORN_PULSE;
				strobe_q <= 1'b1;
			end else if (pre_entry) begin
				bell_q <= 1'b0;
				horn_mode_q <= HORN_PULSE;
				strobe_q <= 1'b1;
			end else if (first_entry) begin
				bell_q <= 1'b1;
			end
		end
	end

	// pulsing pattern, phase restarts whenever the horn is not pulsing
	always_ff @(posedge mclk) begin
		if (reset) begin
			horn_cnt_q <= '0;
			horn_phase_q <= 1'b1;
		end else if (ce) begin
			if (horn_mode_q != HORN_PULSE) begin
				horn_cnt_q <= '0;
				horn_phase_q <= 1'b1;
			end else if (horn_cnt_q == 32'(HORN_HALF_CNT - 1)) begin
				horn_cnt_q <= '0;
				horn_phase_q <= !horn_phase_q;
			end else begin
				horn_cnt_q <= horn_cnt_q + 32'h00000001;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			horn_q <= 1'b0;
		end else if (ce) begin
			case (horn_mode_q)
				HORN_CONT: horn_q <= 1'b1;
				HORN_PULSE: horn_q <= horn_phase_q;
				default: horn_q <= 1'b0;
			endcase
		end
	end

	// release circuit and shutdowns stay on until reset
	always_ff @(posedge mclk) begin
		if (reset) begin
			agent_q <= 1'b0;
			power_q <= 1'b0;
			hvac_q <= 1'b0;
		end else if (ce) begin
			if (release_evt) begin
				agent_q <= 1'b1;
			end
			if (pre_entry || release_evt) begin
				power_q <= 1'b1;
				hvac_q <= 1'b1;
			end
		end
	end

	assign bell_out = bell_q;
	assign horn_out = horn_q;
	assign strobe_out = strobe_q;
	assign agent_release_out = agent_q;
	assign power_shutdown_out = power_q;
	assign hvac_shutdown_out = hvac_q;

	always_comb begin
		status_w = '0;
		status_w[ST_FIRST] = first_alarm_flag;
		status_w[ST_PRE] = prerelease_flag;
		status_w[ST_ABORTED] = abort_occurred_flag;
		status_w[ST_RELEASED] = released_flag;
		status_w[ST_BELL] = bell_q;
		status_w[ST_HORN] = horn_q;
		status_w[ST_STROBE] = strobe_q;
		status_w[ST_AGENT] = agent_q;
		status_w[ST_POWER] = power_q;
		status_w[ST_HVAC] = hvac_q;
		status_w[ST_ABORT_IN] = abort_f;
		status_w[ST_MANUAL_IN] = manual_f;
	end

	// avalon slave: one wait cycle, then the access completes
	assign avs_waitrequest = (avs_read || avs_write) && !ack_q;

	always_ff @(posedge mclk) begin
		if (reset) begin
			ack_q <= 1'b0;
		end else if (ce) begin
			ack_q <= (avs_read || avs_write) && !ack_q;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			rdata_q <= '0;
		end else if (ce && avs_read && !ack_q) begin
			if (avs_address == OFS_CTRL) begin
				rdata_q <= {31'h0, zone_en_q};
			end else if (avs_address == OFS_STATUS) begin
				rdata_q <= status_w;
			end else if (avs_address == OFS_LATCH) begin
				rdata_q <= {26'h0, latch_q};
			end else if (avs_address == OFS_TIMERS) begin
				rdata_q <= {8'h00, remain_v};
			end else begin
				rdata_q <= '0;
			end
		end
	end

	assign avs_readdata = rdata_q;

	always_ff @(posedge mclk) begin
		if (reset) begin
			zone_en_q <= CTRL_RESET[0];
		end else if (ce && avs_write && ack_q) begin
			if (avs_address == OFS_CTRL && avs_byteenable[0]) begin
				zone_en_q <= avs_writedata[CTRL_ZONE_EN_BIT];
			end
		end
	end
endmodule : ars_sequencer
`default_nettype wire

// ===== verif/ars_seq_properties.sv
// checker: signalling and release properties of the sequencer
`default_nettype none
module ars_seq_properties
	import ars_pkg::*;
#(
	parameter int HORN_HALF_CNT = HORN_HALF_CYCLES
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic abort_in,
	input wire logic manual_release_in,
	input wire logic bell_out,
	input wire logic horn_out,
	input wire logic strobe_out,
	input wire logic agent_release_out,
	input wire logic power_shutdown_out,
	input wire logic hvac_shutdown_out
);
	timeunit 1ns;
	timeprecision 1ns;
	int hi_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	always_ff @(posedge mclk) begin
		hi_q <= (reset || !horn_out) ? 0 : hi_q + 1;
	end
	sequence pre_entry_s;
		$rose(power_shutdown_out) && !agent_release_out;
	endsequence
	sequence pre_signal_s;
		strobe_out && !bell_out ##1 horn_out;
	endsequence
	AST_PRE_ENTRY: assert property (pre_entry_s |-> pre_signal_s)
		else $error("prerelease signalling wrong");
	AST_HORN_HALF: assert property ($fell(horn_out) && strobe_out
		|-> hi_q == HORN_HALF_CNT)
		else $error("horn pulse length wrong");
	AST_SHUT_PAIR: assert property (power_shutdown_out == hvac_shutdown_out)
		else $error("shutdown outputs differ");
	AST_REL_SHUT: assert property (agent_release_out |-> power_shutdown_out)
		else $error("release without shutdown");
	AST_ABORT_HOLD: assert property ((abort_in && !manual_release_in)[*8]
		|=> !$rose(agent_release_out))
		else $error("release while abort held");
	AST_AGENT_LATCH: assert property ($past(agent_release_out) && !$past(reset)
		|-> agent_release_out)
		else $error("release output dropped");
	AST_REL_HOLD: assert property (agent_release_out && $past(agent_release_out)
		|-> horn_out && strobe_out && !bell_out)
		else $error("signalling changed after release");
	AST_BELL_ALONE: assert property ($rose(bell_out)
		|-> !strobe_out && !agent_release_out)
		else $error("bell raised with strobe");
	AST_RESET_CLEAR: assert property ($fell(reset)
		|-> !(bell_out || horn_out || strobe_out || agent_release_out || power_shutdown_out))
		else $error("output set after reset");
endmodule : ars_seq_properties
`default_nettype wire

// ===== verif/ars_stations.sv
// station model: non-latching detector, abort and manual contacts
`default_nettype none
module ars_stations (
	input wire logic [5:0] trip,
	input wire logic press,
	input wire logic pull,
	output logic [5:0] detector_in,
	output logic abort_in,
	output logic manual_release_in
);
	timeunit 1ns;
	timeprecision 1ns;
	assign detector_in = trip;
	assign abort_in = press;
	assign manual_release_in = pull;
endmodule : ars_stations
`default_nettype wire

// ===== verif/abort_release_sequencer_bench.sv
// testbench: scenarios for the release sequencer
`default_nettype none
module abort_release_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import ars_pkg::*;
	localparam int T = 20;
	logic mclk = 0, reset = 1, rd = 0, wr = 0, press = 0, pull = 0, ce = 1;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, q;
	logic [5:0] trip = 6'h00, det;
	wire logic [5:0] outs;
	logic abort_w, man_w, wreq;
	int n_mismatch = 0, checked = 0, n;
	always #5 mclk = ~mclk;
	ars_stations u_st (.trip, .press, .pull, .detector_in(det), .abort_in(abort_w),
		.manual_release_in(man_w));
	ars_sequencer #(.TICK_CNT(T), .HORN_HALF_CNT(5)) dut (.mclk, .reset, .ce,
		.avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
		.avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(wreq),
		.detector_in(det), .abort_in(abort_w), .manual_release_in(man_w),
		.bell_out(outs[0]), .horn_out(outs[1]), .strobe_out(outs[2]),
		.agent_release_out(outs[3]), .power_shutdown_out(outs[4]), .hvac_shutdown_out(outs[5]));
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string w);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %0h seen %0h", w, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk);
	endtask : cyc
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		rd <= !w;
		wr <= w;
		do @(posedge mclk); while (wreq !== 1'h0);
		q = rdata;
		rd <= 1'h0;
		wr <= 1'h0;
	endtask : bus
	task automatic sig(input logic [5:0] m, input logic [5:0] e, input string w);
		@(negedge mclk);
		chk(outs & m, e, w);
		@(posedge mclk);
	endtask : sig
	task automatic rise(input int i, input int e, input string w);
		n = 0;
		while (outs[i] !== 1'h1) begin
			@(negedge mclk);
			n++;
		end
		chk(n >= e - 8 && n <= e + 8, 32'h1, w);
		@(posedge mclk);
	endtask : rise
	task automatic restart();
		reset <= 1'h1;
		ce <= 1'h1;
		trip <= 6'h00;
		press <= 1'h0;
		pull <= 1'h0;
		cyc(20);
		reset <= 1'h0;
		cyc(2);
		sig(6'h3F, 6'h00, "reset outputs");
	endtask : restart
	task automatic t_regs();
		restart();
		bus(0, OFS_TIMERS, 0);
		chk(q, {8'h00, TMR_LOADS}, "timer reloads");
		bus(1, OFS_CTRL, 32'h0);
		bus(0, OFS_CTRL, 0);
		chk(q, 32'h0, "ctrl off");
		trip <= 6'h01;
		cyc(10);
		bus(0, OFS_LATCH, 0);
		chk(q, 32'h0, "latch gated");
		trip <= 6'h00;
		cyc(10);
		bus(1, OFS_CTRL, 32'h1);
		bus(0, OFS_CTRL, 0);
		chk(q, 32'h1, "ctrl");
		bus(0, 4'h2, 0);
		chk(q, 32'h0, "unmapped");
	endtask : t_regs
	task automatic t_first();
		restart();
		ce <= 1'h0;
		trip <= 6'h20;
		cyc(10);
		sig(6'h3F, 6'h00, "clock enable freeze");
		ce <= 1'h1;
		cyc(10);
		trip <= 6'h00;
		cyc(10);
		sig(6'h3F, 6'h01, "first alarm");
		bus(0, OFS_LATCH, 0);
		chk(q, 32'h20, "latch");
		bus(0, OFS_STATUS, 0);
		chk(q[4:0], 5'h11, "status first");
	endtask : t_first
	task automatic t_release();
		restart();
		trip <= 6'h03;
		rise(4, 6, "shutdown");
		sig(6'h3D, 6'h34, "prerelease");
		trip <= 6'h07;
		rise(3, BASE_DELAY_S * T, "base delay");
		press <= 1'h1;
		cyc(20);
		sig(6'h3F, 6'h3E, "released");
		bus(0, OFS_STATUS, 0);
		chk(q[3:0], 4'hB, "status release");
	endtask : t_release
	task automatic t_abort();
		restart();
		trip <= 6'h11;
		cyc(100);
		press <= 1'h1;
		cyc(10);
		sig(6'h3F, 6'h31, "abort");
		cyc(BASE_DELAY_S * T + 50);
		sig(6'h08, 6'h00, "abort holds");
		press <= 1'h0;
		rise(2, REARM_DELAY_S * T, "rearm delay");
		sig(6'h09, 6'h00, "rearm");
		rise(3, BASE_DELAY_S * T, "post abort");
		bus(0, OFS_STATUS, 0);
		chk(q[3:0], 4'hF, "status abort");
	endtask : t_abort
	task automatic t_manual();
		restart();
		pull <= 1'h1;
		cyc(10);
		sig(6'h3F, 6'h3E, "manual");
	endtask : t_manual
	initial begin
		t_regs();
		t_first();
		t_release();
		t_abort();
		t_manual();
		print_verdict();
	end
	initial begin
		cyc(20000);
		n_mismatch++;
		print_verdict();
	end
endmodule : abort_release_sequencer_bench
bind ars_sequencer ars_seq_properties #(.HORN_HALF_CNT(HORN_HALF_CNT)) u_props (.mclk, .reset,
	.abort_in, .manual_release_in, .bell_out, .horn_out, .strobe_out, .agent_release_out,
	.power_shutdown_out, .hvac_shutdown_out);
`default_nettype wire
